//--- gpgh_chk_assertions.sv
// Concurrent checks on the port G / port H block, seen from its ports only.
// Assumes the single bus clock and the active-low asynchronous reset.
`timescale 1ns/100ps
module gpgh_chk (
  input wire clk_in,
  input wire nrst_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_readdata_out,
  input wire avs_waitrequest_out,
  input wire [2:0] port_g_pin_in,
  input wire [1:0] port_h_pin_in,
  input wire [2:0] port_g_pin_out,
  input wire [2:0] port_g_pin_oe_out,
  input wire [1:0] port_h_pin_oe_out,
  input wire [4:0] keyboard_wakeup_pin_out
);
  // ==========================================
  // Settling counter: the internal reset lags the pin by two flops
  logic [3:0] up_c;
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) up_c <= 4'h0;
    else if (up_c != 4'h8) up_c <= up_c + 4'h1;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in || up_c != 4'h8);
  wait_single_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("request not answered after one cycle");
  wait_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  ans_cause_a: assert property (!avs_waitrequest_out |-> $past(avs_read_in || avs_write_in))
    else $error("answer without a request");
  read_upper_a: assert property (!avs_waitrequest_out && $past(avs_read_in)
    |-> avs_readdata_out[31:5] == 27'h0) else $error("upper read bits not zero");
  g_oe_write_a: assert property (port_g_pin_oe_out != $past(port_g_pin_oe_out)
    |-> $past(avs_write_in) || $past(avs_write_in, 2)) else $error("port g enable moved alone");
  h_oe_write_a: assert property (port_h_pin_oe_out != $past(port_h_pin_oe_out)
    |-> $past(avs_write_in) || $past(avs_write_in, 2)) else $error("port h enable moved alone");
  g_out_write_a: assert property (port_g_pin_out != $past(port_g_pin_out)
    |-> $past(avs_write_in) || $past(avs_write_in, 2)) else $error("port g level moved alone");
  kbd_follow_a: assert property (keyboard_wakeup_pin_out ==
    $past({port_h_pin_in, port_g_pin_in}, 3)) else $error("wakeup pins lag wrongly");
  cover property (!avs_waitrequest_out && $past(avs_read_in));
  cover property (!avs_waitrequest_out && $past(avs_write_in));
  cover property (port_g_pin_oe_out == 3'h5);
endmodule
bind gpgh_top gpgh_chk chk_u (.*);

//--- gpgh_pads.sv
// Pad model: resolves each pin from the block's enables and an outside level.
// Assumes the outside driver is weak and yields wherever the block drives.
`timescale 1ns/100ps
module gpgh_pads (
  input wire [2:0] g_oe_in,
  input wire [2:0] g_out_in,
  input wire [2:0] g_ext_in,
  input wire [1:0] h_oe_in,
  input wire [1:0] h_out_in,
  input wire [1:0] h_ext_in,
  output wire [2:0] g_pin_out,
  output wire [1:0] h_pin_out
);
  // ==========================================
  // undriven pins follow outside
  assign g_pin_out = (g_oe_in & g_out_in) | (~g_oe_in & g_ext_in);
  assign h_pin_out = (h_oe_in & h_out_in) | (~h_oe_in & h_ext_in);
endmodule

//--- gpgh_regs.vh
// Register map and constants for the port G / port H GPIO block.
// Assumes a 32-bit Avalon-MM slave with word addresses = byte address / 4.
`ifndef GPGH_REGS_VH
`define GPGH_REGS_VH

// Printed offsets are register indices; byte address is four times the index
`define GPGH_IDX_PORT_G_DATA 8'h0A
`define GPGH_IDX_PORT_H_DATA 8'h0B
`define GPGH_IDX_PORT_G_DIR 8'h0C
`define GPGH_IDX_PORT_H_DIR 8'h0D
`define GPGH_IDX_KBI_ENABLE 8'h0E

`define GPGH_G_WIDTH 3
`define GPGH_H_WIDTH 2
`define GPGH_KBI_WIDTH 5
`define GPGH_KBI_G_LSB 0
`define GPGH_KBI_H_LSB 3

`define GPGH_DIR_G_RST 3'h0
`define GPGH_DIR_H_RST 2'h0
`define GPGH_KBI_RST 5'h00
`define GPGH_UNMAPPED_DATA 32'h0000_0000

`endif

//--- gpgh_sync.v
// Two-flop synchroniser for asynchronous pin levels.
// Assumes a single clock domain and an active-low async reset.
`timescale 1ns/100ps
module gpgh_sync #(
  parameter WIDTH = 1
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // First stage feeds only the second stage
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule

//--- gpgh_top.v
// GPIO logic for a 3-pin port G and a 2-pin port H, with keyboard-interrupt
// pin takeover. Assumes an Avalon-MM master on the same clock and external
// pads that resolve level from the output enables.
// Function
// - Port G is three pins and port H two pins, both shared with keyboard interrupts.
// - Each port G pin has a software read/write data latch that reset leaves alone.
// - Each port H pin has a software read/write data latch that reset leaves alone.
// - A port G direction bit of 1 enables the pin driver and 0 leaves it an input.
// - A port H direction bit of 1 enables the pin driver and 0 leaves it an input.
// - Reset clears the port G direction bits, which software can read and write.
// - Reset clears the port H direction bits, which software can read and write.
// - Reading port G data returns the latch for pins set as outputs.
// - Reading port G data returns the pin level for pins set as inputs.
// - Reading port H data returns the latch for pins set as outputs.
// - Reading port H data returns the synchronised pin level for input pins.
// - Data writes with byte lane 0 enabled update the latch whatever the direction.
// - A set keyboard enable bit makes a port G pin an interrupt input over its direction.
// - Keyboard enable bits 4 and 3 make the port H pins interrupt inputs.
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/100ps
`include "gpgh_regs.vh"

module gpgh_top (
  input wire clk_in,
  input wire nrst_in,
  // Avalon-MM slave, word addressed
  input wire [7:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [3:0] avs_byteenable_in,
  input wire [31:0] avs_writedata_in,
  output reg [31:0] avs_readdata_out,
  output reg avs_waitrequest_out,
  // Port G pins
  input wire [2:0] port_g_pin_in,
  output reg [2:0] port_g_pin_out,
  output reg [2:0] port_g_pin_oe_out,
  // Port H pins
  input wire [1:0] port_h_pin_in,
  output reg [1:0] port_h_pin_out,
  output reg [1:0] port_h_pin_oe_out,
  // Synchronised pin levels handed to the keyboard interrupt logic
  output reg [4:0] keyboard_wakeup_pin_out
);

  // ===========================================================
  // Reset release
  // ===========================================================
  reg rst_meta_r;
  reg rst_n_r;

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ===========================================================
  // Pin input synchronisation
  // ===========================================================
  wire [4:0] pins_sync;

  // G pins low, H pins high
  gpgh_sync #(
    .WIDTH(5)
  ) u_pin_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_r),
    .async_in({port_h_pin_in, port_g_pin_in}),
    .sync_out(pins_sync)
  );

  wire [2:0] g_pin_lvl = pins_sync[2:0];
  wire [1:0] h_pin_lvl = pins_sync[4:3];

  // ===========================================================
  // Registers
  // ===========================================================
  reg [2:0] port_g_data_latch_r;
  reg [1:0] port_h_data_latch_r;
  reg [2:0] port_g_direction_r;
  reg [1:0] port_h_direction_r;
  reg [4:0] keyboard_interrupt_enable_r;

  // Request is answered on the second edge: waitrequest drops for one cycle
  reg ack_r;
  wire req = avs_read_in | avs_write_in;
  wire wr_go = avs_write_in & ack_r;
  wire lane0 = avs_byteenable_in[0];

  wire sel_g_data = (avs_address_in == `GPGH_IDX_PORT_G_DATA);
  wire sel_h_data = (avs_address_in == `GPGH_IDX_PORT_H_DATA);
  wire sel_g_dir = (avs_address_in == `GPGH_IDX_PORT_G_DIR);
  wire sel_h_dir = (avs_address_in == `GPGH_IDX_PORT_H_DIR);
  wire sel_kbi = (avs_address_in == `GPGH_IDX_KBI_ENABLE);

  always @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // Latches have no reset; power-up content is undefined
  always @(posedge clk_in) begin
    if (wr_go && lane0 && sel_g_data) begin
      port_g_data_latch_r <= avs_writedata_in[2:0];
    end
    if (wr_go && lane0 && sel_h_data) begin
      port_h_data_latch_r <= avs_writedata_in[1:0];
    end
  end

  always @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      port_g_direction_r <= `GPGH_DIR_G_RST;
      port_h_direction_r <= `GPGH_DIR_H_RST;
      keyboard_interrupt_enable_r <= `GPGH_KBI_RST;
    end else if (wr_go && lane0) begin
      if (sel_g_dir) begin
        port_g_direction_r <= avs_writedata_in[2:0];
      end
      if (sel_h_dir) begin
        port_h_direction_r <= avs_writedata_in[1:0];
      end
      if (sel_kbi) begin
        keyboard_interrupt_enable_r <= avs_writedata_in[4:0];
      end
    end
  end

  // ===========================================================
  // Read path
  // ===========================================================
  reg [31:0] rd_nxt;

  always @* begin
    rd_nxt = `GPGH_UNMAPPED_DATA;
    if (sel_g_data) begin
      // Latch when output, pin when input
      rd_nxt[2:0] = (port_g_direction_r & port_g_data_latch_r) |
                    (~port_g_direction_r & g_pin_lvl);
    end else if (sel_h_data) begin
      // Latch when output, pin when input
      rd_nxt[1:0] = (port_h_direction_r & port_h_data_latch_r) |
                    (~port_h_direction_r & h_pin_lvl);
    end else if (sel_g_dir) begin
      rd_nxt[2:0] = port_g_direction_r;
    end else if (sel_h_dir) begin
      rd_nxt[1:0] = port_h_direction_r;
    end else if (sel_kbi) begin
      rd_nxt[4:0] = keyboard_interrupt_enable_r;
    end
  end

  always @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      avs_readdata_out <= 32'h0000_0000;
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= ~(req & ~ack_r);
      if (avs_read_in && !ack_r) begin
        avs_readdata_out <= rd_nxt;
      end
    end
  end

  // ===========================================================
  // Pin drivers
  // ===========================================================
  // Direction still selects the read source even while the keyboard
  // function owns the pin; only the driver is overridden.
  wire [2:0] kbi_g = keyboard_interrupt_enable_r[2:0];
  wire [1:0] kbi_h = keyboard_interrupt_enable_r[4:3];

  always @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      port_g_pin_oe_out <= 3'h0;
      port_h_pin_oe_out <= 2'h0;
      port_g_pin_out <= 3'h0;
      port_h_pin_out <= 2'h0;
      keyboard_wakeup_pin_out <= 5'h00;
    end else begin
      port_g_pin_oe_out <= port_g_direction_r & ~kbi_g;
      port_h_pin_oe_out <= port_h_direction_r & ~kbi_h;
      // Latch drives as soon as direction turns on
      port_g_pin_out <= port_g_data_latch_r;
      port_h_pin_out <= port_h_data_latch_r;
      keyboard_wakeup_pin_out <= pins_sync;
    end
  end

endmodule

//--- gpgh_top_tb.sv
// Self-checking bench for the port G / port H block over Avalon-MM.
// Assumes a pad model in front of the pins and one 200 MHz clock.
`timescale 1ns/100ps
module gpgh_top_tb;
  // ==========================================
  logic clk_in = 1'b0, nrst = 1'b0, a_rd = 1'b0, a_wr = 1'b0;
  logic [7:0] a_addr = 8'h00;
  logic [3:0] a_be = 4'hF;
  logic [31:0] a_wd = 32'h0000_0000, rd_v, rdata;
  logic [2:0] g_ext = 3'h5, g_out, g_oe, g_pin;
  logic [1:0] h_ext = 2'h2, h_out, h_oe, h_pin;
  logic wreq;
  logic [4:0] keyboard_wakeup_pin;
  int bad_count = 0, checks_done = 0;
  always #2.5 clk_in = ~clk_in;
  gpgh_top dut_u (.clk_in(clk_in), .nrst_in(nrst), .avs_address_in(a_addr),
    .avs_read_in(a_rd), .avs_write_in(a_wr), .avs_byteenable_in(a_be),
    .avs_writedata_in(a_wd), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .port_g_pin_in(g_pin), .port_g_pin_out(g_out), .port_g_pin_oe_out(g_oe),
    .port_h_pin_in(h_pin), .port_h_pin_out(h_out), .port_h_pin_oe_out(h_oe),
    .keyboard_wakeup_pin_out(keyboard_wakeup_pin));
  gpgh_pads pads_u (.g_oe_in(g_oe), .g_out_in(g_out), .g_ext_in(g_ext), .h_oe_in(h_oe),
    .h_out_in(h_out), .h_ext_in(h_ext), .g_pin_out(g_pin), .h_pin_out(h_pin));
  // Waitrequest and read data are taken at the rising edge that ends the wait
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    a_addr <= a;
    a_wd <= d;
    a_wr <= w;
    a_rd <= !w;
    do begin
      @(posedge clk_in);
      n++;
    end while (wreq !== 1'b0 && n < 40);
    if (n >= 40) bad_count++;
    rd_v = rdata;
    a_rd <= 1'b0;
    a_wr <= 1'b0;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    acc(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd_v);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task do_reset;
    nrst <= 1'b0;
    repeat (5) @(posedge clk_in);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_in);
  endtask
  initial begin
    #20000;
    bad_count++;
    close_out;
  end
  initial begin
    do_reset;
    rdchk(8'h0C, 8'h00, "g dir");
    rdchk(8'h0D, 8'h00, "h dir");
    rdchk(8'h0E, 8'h00, "kbi enable");
    rdchk(8'h0A, 8'h05, "g pins");
    rdchk(8'h0B, 8'h02, "h pins");
    acc(1'b1, 8'h0A, 8'h03);
    rdchk(8'h0A, 8'h05, "g input after write");
    acc(1'b1, 8'h0C, 8'h07);
    rdchk(8'h0A, 8'h03, "g latch");
    chk("g oe", 8'h07, g_oe);
    chk("g out", 8'h03, g_out);
    acc(1'b1, 8'h0B, 8'h01);
    acc(1'b1, 8'h0D, 8'h01);
    rdchk(8'h0B, 8'h03, "h mixed");
    chk("h oe", 8'h01, h_oe);
    chk("h out", 8'h01, h_out);
    a_be <= 4'h0;
    acc(1'b1, 8'h0C, 8'h00);
    a_be <= 4'hF;
    rdchk(8'h0C, 8'h07, "g dir kept");
    acc(1'b1, 8'h20, 32'hFFFF_FFFF);
    rdchk(8'h20, 8'h00, "unmapped");
    acc(1'b1, 8'h0E, 8'h0A);
    repeat (4) @(posedge clk_in);
    rdchk(8'h0A, 8'h03, "g read under kbi");
    chk("g oe kbi", 8'h05, g_oe);
    chk("h oe kbi", 8'h00, h_oe);
    chk("kbd pins", 8'h11, keyboard_wakeup_pin);
    do_reset;
    rdchk(8'h0C, 8'h00, "g dir reset");
    acc(1'b1, 8'h0C, 8'h07);
    rdchk(8'h0A, 8'h03, "g latch kept");
    acc(1'b1, 8'h0D, 8'h03);
    rdchk(8'h0B, 8'h01, "h latch kept");
    close_out;
  end
endmodule
